// [hw/cmd_message_parser.sv]
// Program message parser: splits ASCII instructions, holds them until the message ends.
// Assumes bytes and the end flag come from a bus front end on i_ref_clk.
`timescale 1ns/1ns
// Functional notes
// R1: Instructions are queued and released only after the message end.
// R2: Message ends on a linefeed byte, an end flag on a byte, or both.
// R3: Host drives the end line low with the final byte.
// R4: One or more spaces separate header and data; any run is accepted.
// R5: A header directly followed by the terminator is accepted.
// R6: Commas split parameters; spaces around commas are tolerated.
// R7: Colons split a header into keyword mnemonics.
// R8: A question mark right after the last mnemonic marks a query.
// R9: Keyword matching ignores letter case.
// R10: Response letters leave in upper case.
// R11: Full and short keyword forms match the same mnemonic.
// R12: Long keywords shorten to four characters, three if the fourth is a vowel.
// R13: Keywords of four or fewer characters are their own short form.
// R14: Host starts a simple header at message start or after a colon.
// R15: First mnemonic of a compound header selects subsystem, second the function.
// R16: A common header is an asterisk immediately followed by its mnemonic.
// R17: Terminator or leading colon returns the position to the root.
// R18: Common instructions leave the current position unchanged.
// R19: Unknown or malformed instructions are dropped and flag a command error.
module cmd_message_parser
  import cmd_parse_pkg::*;
(
  // Clock, reset, enable
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  // Received bytes
  input wire logic [7:0] i_rx_byte,
  input wire logic i_rx_valid,
  input wire logic i_rx_eoi_n,
  output logic o_rx_ready,
  // Parsed instructions
  output logic o_inst_valid,
  output inst_t o_inst_data,
  input wire logic i_inst_ready,
  // Query responses
  input wire logic [7:0] i_resp_byte,
  input wire logic i_resp_valid,
  output logic [7:0] o_resp_byte,
  output logic o_resp_valid,
  // Errors
  output logic o_cmd_error
);
  parse_state_t state;
  parse_state_t next_state;
  logic pend_term;
  logic acc;
  logic ev;
  logic eoi_byte;
  logic [7:0] evc;
  logic c_term, c_semi, c_colon, c_query, c_star, c_space, c_comma, c_word;
  logic append, start_inst, finish, push, err_now, hdr_err;
  logic set_common, set_colon, set_query, param_inc;
  logic [63:0] mbuf;
  logic [3:0] mlen;
  logic [IDX_W:0] hit;
  logic [IDX_W-1:0] first, second, hv_first, hv_second;
  logic [1:0] mcnt, hv_cnt;
  logic common, colon, query;
  logic [3:0] nparams;
  logic pos_valid;
  logic [IDX_W-1:0] pos;
  inst_t rec;
  inst_t q_mem [QUEUE_DEPTH];
  logic [2:0] wr_ptr, rd_ptr;
  logic [3:0] q_count;
  logic q_full, pop;

  inst_stream_if up_if ();
  inst_stream_if dn_if ();

  assign acc = i_rx_valid && o_rx_ready;
  // The end line is active low and qualifies the byte it travels with.
  assign eoi_byte = acc && !i_rx_eoi_n && i_rx_byte != LINE_TERMINATOR_CHAR; // see R3
  assign ev = acc || pend_term;
  assign evc = pend_term ? LINE_TERMINATOR_CHAR : i_rx_byte;
  assign c_term = evc == LINE_TERMINATOR_CHAR; // see R2
  assign c_semi = evc == CH_SEMI;
  assign c_colon = evc == CH_COLON;
  assign c_query = evc == CH_QUERY;
  assign c_star = evc == CH_STAR;
  assign c_space = evc == CH_SPACE;
  assign c_comma = evc == CH_COMMA;
  assign c_word = !(c_term || c_semi || c_colon || c_query || c_star || c_space || c_comma);
  assign q_full = q_count == QUEUE_DEPTH;

  // Mnemonics are stored upper-cased, so lower- and upper-case forms compare as equal.
  assign hit = kw_lookup(mbuf, mlen); // see R9, R11, R12, R13
  assign finish = ev && state == ST_HDR && (c_colon || c_query || c_space || c_term || c_semi);
  assign hdr_err = !hit[IDX_W] || mcnt == 2'h2 || (c_colon && common); // see R16, R19

  always_comb begin
    next_state = state;
    append = 1'b0;
    start_inst = 1'b0;
    push = 1'b0;
    err_now = 1'b0;
    set_common = 1'b0;
    set_colon = 1'b0;
    set_query = 1'b0;
    param_inc = 1'b0;
    if (ev) begin
      case (state)
        ST_IDLE: begin
          if (c_term) begin
            next_state = ST_FLUSH;
          end else if (c_colon) begin
            set_colon = 1'b1;
            start_inst = 1'b1;
            next_state = ST_HDR;
          end else if (c_star) begin
            set_common = 1'b1; // see R16
            start_inst = 1'b1;
            next_state = ST_HDR;
          end else if (c_word) begin
            append = 1'b1;
            start_inst = 1'b1;
            next_state = ST_HDR;
          end else if (!(c_space || c_semi)) begin
            err_now = 1'b1;
          end
        end
        ST_HDR: begin
          if (c_word) begin
            if (mlen == KW_MAX_LEN) err_now = 1'b1;
            else append = 1'b1;
          end else if (!finish || hdr_err) begin
            err_now = 1'b1; // see R19
          end else if (c_query) begin
            set_query = 1'b1; // see R8
            next_state = ST_SEP;
          end else if (c_space) begin
            next_state = ST_SEP; // see R4
          end else if (c_term || c_semi) begin
            push = 1'b1; // see R5
          end
        end
        ST_SEP: begin
          if (c_comma) begin
            err_now = 1'b1;
          end else if (c_term || c_semi) begin
            push = 1'b1;
          end else if (!c_space) begin
            param_inc = 1'b1;
            next_state = ST_DATA;
          end
        end
        ST_DATA: begin
          if (c_comma) next_state = ST_COMMA; // see R6
          else if (c_term || c_semi) push = 1'b1;
        end
        ST_COMMA: begin
          if (c_comma || c_term || c_semi) begin
            err_now = 1'b1;
          end else if (!c_space) begin
            param_inc = 1'b1; // see R6
            next_state = ST_DATA;
          end
        end
        ST_SKIP: begin
        end
        default: begin
        end
      endcase
      if (push && q_full) begin
        push = 1'b0;
        err_now = 1'b1;
      end
      if (err_now) next_state = ST_SKIP;
      if ((c_term || c_semi) && state != ST_IDLE && state != ST_FLUSH) begin
        next_state = c_term ? ST_FLUSH : ST_IDLE; // see R2
      end
    end
    if (state == ST_FLUSH && q_count == 4'h0) next_state = ST_IDLE;
  end

  // Sequencing and byte acceptance; ready drops while the queue drains.
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state <= ST_IDLE;
      pend_term <= 1'b0;
      o_rx_ready <= 1'b1;
    end else if (i_clk_en) begin
      state <= next_state;
      pend_term <= eoi_byte; // see R2
      o_rx_ready <= next_state != ST_FLUSH && !eoi_byte; // see R1
    end
  end

  // Mnemonic collection.
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      mbuf <= '0;
      mlen <= 4'h0;
    end else if (i_clk_en) begin
      if (append) begin
        mbuf <= {(start_inst ? 56'h0 : mbuf[55:0]), to_upper(evc)}; // see R9
        mlen <= start_inst ? 4'h1 : mlen + 4'h1;
      end else if (finish || start_inst) begin
        mbuf <= '0;
        mlen <= 4'h0;
      end
    end
  end

  // Header fields of the instruction being parsed.
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      first <= '0;
      second <= '0;
      mcnt <= 2'h0;
      common <= 1'b0;
      colon <= 1'b0;
      query <= 1'b0;
      nparams <= 4'h0;
    end else if (i_clk_en) begin
      if (start_inst) begin
        mcnt <= 2'h0;
        common <= set_common;
        colon <= set_colon;
        query <= 1'b0;
        nparams <= 4'h0;
      end else begin
        if (finish && !hdr_err) begin
          first <= hv_first; // see R7
          second <= hv_second;
          mcnt <= hv_cnt;
        end
        if (set_query) query <= 1'b1;
        if (param_inc && nparams != NPARAM_MAX) nparams <= nparams + 4'h1;
      end
    end
  end

  // Header view including a mnemonic that closes in this cycle.
  always_comb begin
    hv_first = first;
    hv_second = second;
    hv_cnt = mcnt;
    if (finish && mcnt == 2'h0) begin
      hv_first = hit[IDX_W-1:0];
      hv_cnt = 2'h1;
    end else if (finish) begin
      hv_second = hit[IDX_W-1:0];
      hv_cnt = 2'h2;
    end
    rec.common = common;
    rec.query = query;
    rec.nparams = nparams;
    if (common) begin
      rec.has_sel = 1'b0;
      rec.sel = '0;
      rec.func = hv_first;
    end else if (hv_cnt == 2'h2) begin
      rec.has_sel = 1'b1; // see R15
      rec.sel = hv_first;
      rec.func = hv_second;
    end else begin
      rec.has_sel = pos_valid && !colon;
      rec.sel = pos;
      rec.func = hv_first;
    end
  end

  // Current position in the command hierarchy.
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pos_valid <= 1'b0;
      pos <= '0;
    end else if (i_clk_en) begin
      if ((ev && c_term) || (start_inst && set_colon)) begin
        pos_valid <= 1'b0; // see R17
      end else if (push && !common && hv_cnt == 2'h2) begin
        pos_valid <= 1'b1; // see R18
        pos <= hv_first;
      end
    end
  end

  // Held instructions, drained into the output buffer after the message end.
  assign pop = up_if.valid && up_if.ready;
  assign up_if.valid = state == ST_FLUSH && q_count != 4'h0; // see R1
  assign up_if.data = q_mem[rd_ptr];

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wr_ptr <= 3'h0;
      rd_ptr <= 3'h0;
      q_count <= 4'h0;
      for (int i = 0; i < int'(QUEUE_DEPTH); i++) q_mem[i] <= '0;
    end else if (i_clk_en) begin
      if (push) begin
        q_mem[wr_ptr] <= rec;
        wr_ptr <= wr_ptr + 3'h1;
      end
      if (pop) rd_ptr <= rd_ptr + 3'h1;
      if (push && !pop) q_count <= q_count + 4'h1;
      else if (pop && !push) q_count <= q_count - 4'h1;
    end
  end

  inst_skid_buffer u_buf (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_clk_en(i_clk_en),
    .up(up_if.cons),
    .dn(dn_if.prod)
  );
  assign o_inst_valid = dn_if.valid;
  assign o_inst_data = dn_if.data;
  assign dn_if.ready = i_inst_ready;

  // Error pulse and upper-case response path.
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_cmd_error <= 1'b0;
      o_resp_byte <= 8'h00;
      o_resp_valid <= 1'b0;
    end else if (i_clk_en) begin
      o_cmd_error <= err_now; // see R19
      o_resp_byte <= to_upper(i_resp_byte); // see R10
      o_resp_valid <= i_resp_valid;
    end
  end

  AST_HOLD_UNTIL_END: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // see R1
    up_if.valid |-> state == ST_FLUSH && !o_rx_ready)
    else $error("instruction released before message end");
  AST_LF_ENDS: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // see R2
    i_clk_en && acc && i_rx_byte == LINE_TERMINATOR_CHAR |=> state == ST_FLUSH && !pos_valid)
    else $error("linefeed did not end the message");
  AST_EOI_ENDS: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // see R3
    i_clk_en && eoi_byte |=> pend_term && !o_rx_ready ##1 (state == ST_FLUSH || !$past(i_clk_en)))
    else $error("end flag did not end the message");
  AST_SPACE_RUN: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // see R4
    i_clk_en && acc && state == ST_SEP && i_rx_byte == CH_SPACE |=> state == ST_SEP)
    else $error("space run left the separator state");
  AST_QUERY: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // see R8
    i_clk_en && acc && state == ST_HDR && c_query && !err_now |=> query && state == ST_SEP)
    else $error("question mark not taken as query");
  AST_COMMON_POS: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // see R18
    i_clk_en && push && common && !c_term |=> pos_valid == $past(pos_valid) && pos == $past(pos))
    else $error("common instruction moved the position");
  AST_COMMON_GAP: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // see R16
    i_clk_en && acc && state == ST_HDR && common && mlen == 4'h0 && c_space |=> o_cmd_error)
    else $error("space after asterisk accepted");
  AST_UPPER: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // see R10
    o_resp_valid |-> !(o_resp_byte >= CH_LOWER_A && o_resp_byte <= CH_LOWER_Z))
    else $error("lower-case letter in response");
  AST_ERR_DROP: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // see R19
    i_clk_en && err_now && !c_term && !c_semi |=> state == ST_SKIP && o_cmd_error)
    else $error("bad instruction not discarded");
endmodule : cmd_message_parser

// [inc/cmd_parse_pkg.sv]
// Constants, record type and helper functions for the program message parser.
// Assumes ASCII bytes arrive one at a time from a bus front end on the same clock.
package cmd_parse_pkg;

  // Character codes the parser reacts to.
  localparam logic [7:0] LINE_TERMINATOR_CHAR = 8'h0A;
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_STAR = 8'h2A;
  localparam logic [7:0] CH_COMMA = 8'h2C;
  localparam logic [7:0] CH_COLON = 8'h3A;
  localparam logic [7:0] CH_SEMI = 8'h3B;
  localparam logic [7:0] CH_QUERY = 8'h3F;
  localparam logic [7:0] CH_LOWER_A = 8'h61;
  localparam logic [7:0] CH_LOWER_Z = 8'h7A;
  localparam logic [7:0] CASE_BIT = 8'h20;
  localparam logic [39:0] VOWELS = "AEIOU";

  // Keyword table, stored in upper case and right-justified.
  localparam int KW_COUNT = 8;
  localparam int IDX_W = 3;
  localparam logic [3:0] KW_MAX_LEN = 4'h8;
  localparam logic [3:0] SHORT_LEN = 4'h4;
  localparam logic [63:0] KW_TEXT [KW_COUNT] = '{
    "CHANNEL", "TIMEBASE", "RANGE", "DELAY", "TYPE", "TRIGGER", "CLS", "ESR"};
  localparam logic [3:0] KW_LEN [KW_COUNT] = '{
    4'h7, 4'h8, 4'h5, 4'h5, 4'h4, 4'h7, 4'h3, 4'h3};

  // Instruction queue depth and parameter counter limit.
  localparam logic [3:0] QUEUE_DEPTH = 4'h8;
  localparam logic [3:0] NPARAM_MAX = 4'hF;

  typedef enum logic [6:0] {
    ST_IDLE  = 7'b0000001,
    ST_HDR   = 7'b0000010,
    ST_SEP   = 7'b0000100,
    ST_DATA  = 7'b0001000,
    ST_COMMA = 7'b0010000,
    ST_SKIP  = 7'b0100000,
    ST_FLUSH = 7'b1000000
  } parse_state_t;

  typedef struct packed {
    logic common;
    logic query;
    logic has_sel;
    logic [IDX_W-1:0] sel;
    logic [IDX_W-1:0] func;
    logic [3:0] nparams;
  } inst_t;

  function automatic logic [7:0] to_upper(input logic [7:0] c);
    to_upper = (c >= CH_LOWER_A && c <= CH_LOWER_Z) ? (c ^ CASE_BIT) : c;
  endfunction : to_upper

  function automatic logic is_vowel(input logic [7:0] c);
    is_vowel = 1'b0;
    for (int v = 0; v < 5; v++) begin
      if (c == VOWELS[8*v +: 8]) is_vowel = 1'b1;
    end
  endfunction : is_vowel

  // Short form: four characters, or three when the fourth is a vowel; keywords of four or fewer characters keep their own length.
  function automatic logic [3:0] short_len(input int k);
    if (KW_LEN[k] > SHORT_LEN) begin
      short_len = is_vowel(KW_TEXT[k][8*int'(KW_LEN[k]) - 32 +: 8]) ? 4'h3 : SHORT_LEN;
    end else begin
      short_len = KW_LEN[k];
    end
  endfunction : short_len

  // Returns the found flag above the keyword index.
  function automatic logic [IDX_W:0] kw_lookup(input logic [63:0] text, input logic [3:0] len);
    logic [3:0] slen;
    kw_lookup = '0;
    for (int k = 0; k < KW_COUNT; k++) begin
      slen = short_len(k);
      if (len == KW_LEN[k] && text == KW_TEXT[k]) begin
        kw_lookup = {1'b1, IDX_W'(k)};
      end else if (len == slen && text == (KW_TEXT[k] >> (8 * int'(KW_LEN[k] - slen)))) begin
        kw_lookup = {1'b1, IDX_W'(k)};
      end
    end
  endfunction : kw_lookup

endpackage : cmd_parse_pkg

// [inc/inst_stream_if.sv]
// Valid/ready stream of parsed instructions between parser modules.
// Assumes both ends share one clock.
`timescale 1ns/1ns
interface inst_stream_if;
  import cmd_parse_pkg::*;
  logic valid;
  logic ready;
  inst_t data;
  modport prod (output valid, output data, input ready);
  modport cons (input valid, input data, output ready);
endinterface : inst_stream_if

// [hw/inst_skid_buffer.sv]
// Two-entry skid buffer for parsed instructions.
// Assumes a single clock, active-high async reset and a freezing clock enable.
`timescale 1ns/1ns
module inst_skid_buffer
  import cmd_parse_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  // Streams
  inst_stream_if.cons up,
  inst_stream_if.prod dn
);
  logic main_valid;
  logic skid_valid;
  inst_t main_data;
  inst_t skid_data;
  logic take;
  logic give;

  assign take = up.valid && !skid_valid;
  assign give = main_valid && dn.ready;
  assign up.ready = !skid_valid;
  assign dn.valid = main_valid;
  assign dn.data = main_data;

  // A stalled receiver parks one word in the skid slot and drops ready.
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      main_valid <= 1'b0;
      skid_valid <= 1'b0;
      main_data <= '0;
      skid_data <= '0;
    end else if (i_clk_en) begin
      if (!main_valid || give) begin
        if (skid_valid) begin
          main_data <= skid_data;
          main_valid <= 1'b1;
          skid_valid <= 1'b0;
        end else begin
          main_valid <= take;
          main_data <= up.data;
        end
      end else if (take) begin
        skid_valid <= 1'b1;
        skid_data <= up.data;
      end
    end
  end
endmodule : inst_skid_buffer

// [dv/host_msg_source.sv]
// Host side model: offers program message bytes one at a time with valid/ready.
// Assumes the parser samples bytes on rising edges of i_ref_clk while i_clk_en is high.
`timescale 1ns/1ns
module host_msg_source (
  // Clock and enable
  input wire logic i_ref_clk,
  input wire logic i_clk_en,
  // Byte stream towards the parser
  input wire logic i_rx_ready,
  output logic [7:0] o_rx_byte,
  output logic o_rx_valid,
  output logic o_rx_eoi_n,
  // Message in progress
  output logic o_busy
);
  initial begin
    o_rx_byte = 8'h00;
    o_rx_valid = 1'b0;
    o_rx_eoi_n = 1'b1;
    o_busy = 1'b0;
  end

  // Call just after a rising edge; returns at the edge that takes the last byte.
  // Idle gaps show the inverted last byte so a stale value is never mistaken for data.
  task automatic send_msg(input string s, input bit eoi_last);
    o_busy <= 1'b1;
    for (int i = 0; i < s.len(); i++) begin
      if ($urandom_range(3) == 0) begin
        o_rx_valid <= 1'b0;
        o_rx_byte <= ~o_rx_byte;
        repeat ($urandom_range(3, 1)) @(posedge i_ref_clk);
      end
      o_rx_byte <= s[i];
      o_rx_eoi_n <= !(eoi_last && i == s.len() - 1);
      o_rx_valid <= 1'b1;
      do @(posedge i_ref_clk); while (!(i_rx_ready === 1'b1 && i_clk_en === 1'b1));
    end
    o_rx_valid <= 1'b0;
    o_rx_eoi_n <= 1'b1;
    o_rx_byte <= ~o_rx_byte;
    o_busy <= 1'b0;
  endtask : send_msg
endmodule : host_msg_source

// [dv/command_message_parser_tb_top.sv]
// Self-checking bench for the program message parser.
// Assumes the parser package is compiled first; the host model drives the byte side.
`timescale 1ns/1ns
module command_message_parser_tb_top;
  import cmd_parse_pkg::*;
  logic ref_clk, sys_rst, clk_en, inst_ready, hold_off, busy;
  logic rx_valid, rx_eoi_n, rx_ready, inst_valid, resp_valid_in, resp_valid, cmd_error;
  logic [7:0] rx_byte, resp_byte_in, resp_byte, rb, rb_exp;
  inst_t inst_data, e, s;
  inst_t exp_q[$];
  logic [7:0] resp_q[$];
  int mismatches = 0, tests_run = 0, err_seen = 0, err_exp = 0, cycles = 0;
  string long_kw [8] = '{"CHANNEL", "TIMEBASE", "RANGE", "DELAY", "TYPE", "TRIGGER", "CLS", "ESR"};
  string short_kw [8] = '{"CHAN", "TIM", "RANG", "DEL", "TYPE", "TRIG", "CLS", "ESR"};
  logic [7:0] edge_tab [4] = '{8'h60, 8'h61, 8'h7A, 8'h7B};
  string msg;

  cmd_message_parser i_dut (.i_ref_clk(ref_clk), .i_sys_rst(sys_rst), .i_clk_en(clk_en),
    .i_rx_byte(rx_byte), .i_rx_valid(rx_valid), .i_rx_eoi_n(rx_eoi_n), .o_rx_ready(rx_ready),
    .o_inst_valid(inst_valid), .o_inst_data(inst_data), .i_inst_ready(inst_ready),
    .i_resp_byte(resp_byte_in), .i_resp_valid(resp_valid_in), .o_resp_byte(resp_byte),
    .o_resp_valid(resp_valid), .o_cmd_error(cmd_error));

  host_msg_source i_host (.i_ref_clk(ref_clk), .i_clk_en(clk_en), .i_rx_ready(rx_ready),
    .o_rx_byte(rx_byte), .o_rx_valid(rx_valid), .o_rx_eoi_n(rx_eoi_n), .o_busy(busy));

  task automatic check(input logic [15:0] seen, input logic [15:0] expv);
    tests_run++;
    if (seen !== expv) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, expv);
    end
  endtask : check

  task automatic give_verdict();
    if (mismatches == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict

  function automatic inst_t mk(input logic c, q, h, input logic [2:0] sl, f,
                               input logic [3:0] n);
    mk = {c, q, h, sl, f, n};
  endfunction : mk

  function automatic string mix(input string t);
    string r;
    r = t;
    for (int i = 0; i < r.len(); i++) begin
      if (r[i] >= "A" && r[i] <= "Z" && $urandom_range(1) == 1) r[i] = r[i] + 8'h20;
    end
    return r;
  endfunction : mix

  // Sends one message, then waits for its instructions to drain and checks errors.
  task automatic run(input string t, input bit eoi, input int nerr);
    int n;
    err_exp += nerr;
    i_host.send_msg(t, eoi);
    n = 0;
    while ((exp_q.size() != 0 || rx_ready !== 1'b1) && n < 400) begin
      @(posedge ref_clk);
      n++;
    end
    check(16'(exp_q.size()), 16'h0000);
    exp_q.delete();
    // Error pulses hold while the enable is low, so count enabled edges only.
    n = 0;
    while (n < 3) begin
      @(posedge ref_clk);
      if (clk_en === 1'b1) n++;
    end
    check(16'(err_seen), 16'(err_exp));
  endtask : run

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    clk_en <= ($urandom_range(7) != 0);
    inst_ready <= hold_off ? 1'b0 : ($urandom_range(3) != 0);
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      give_verdict();
    end
  end

  // Watches the outputs and compares each result with the oldest note.
  always @(posedge ref_clk) begin
    if (sys_rst === 1'b0) begin
      if (busy === 1'b1) check({15'h0000, inst_valid}, 16'h0000);
      if (clk_en === 1'b1 && inst_valid === 1'b1 && inst_ready === 1'b1) begin
        s = inst_data;
        e = (exp_q.size() != 0) ? exp_q.pop_front() : ~inst_data;
        if (e.has_sel === 1'b0) begin
          e.sel = '0;
          s.sel = '0;
        end
        check(16'(s), 16'(e));
      end
      if (clk_en === 1'b1 && cmd_error === 1'b1) err_seen++;
      if (clk_en === 1'b1 && resp_valid === 1'b1) begin
        rb_exp = (resp_q.size() != 0) ? resp_q.pop_front() : ~resp_byte;
        check({8'h00, resp_byte}, {8'h00, rb_exp});
      end
    end
  end

  initial begin
    void'($urandom(32'hCBCEC8BE));
    sys_rst = 1'b1;
    clk_en = 1'b1;
    inst_ready = 1'b1;
    hold_off = 1'b0;
    resp_byte_in = 8'h00;
    resp_valid_in = 1'b0;
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    exp_q.push_back(mk(1, 0, 0, 0, 6, 0));
    run("*CLS\n", 0, 0);
    exp_q.push_back(mk(1, 0, 0, 0, 6, 0));
    run("*cls", 1, 0);
    exp_q.push_back(mk(1, 1, 0, 0, 7, 0));
    run("*ESR?\n", 1, 0);
    for (int k = 0; k < 8; k++) begin
      exp_q.push_back(mk(0, 1, 0, 0, 3'(k), 0));
      run({":", mix(long_kw[k]), "?\n"}, 0, 0);
      exp_q.push_back(mk(0, 0, 0, 0, 3'(k), 0));
      run({mix(short_kw[k]), "\n"}, 1'($urandom_range(1)), 0);
    end
    run(":TIME\n", 0, 1);
    run("CHA 1\n", 0, 1);
    run("* CLS\n", 0, 1);
    exp_q.push_back(mk(0, 0, 1, 0, 2, 3));
    run(":CHAN:RANG    1 , 2,3\n", 0, 0);
    exp_q.push_back(mk(0, 0, 1, 1, 3, 1));
    exp_q.push_back(mk(0, 1, 1, 1, 4, 0));
    exp_q.push_back(mk(0, 0, 0, 0, 4, 0));
    run(":TIM:DEL 5;TYPE?;:TYPE\n", 0, 0);
    exp_q.push_back(mk(0, 0, 1, 1, 2, 1));
    exp_q.push_back(mk(1, 1, 0, 0, 7, 0));
    exp_q.push_back(mk(0, 0, 1, 1, 3, 1));
    run(":TIM:RANG 1;*ESR?;DEL 2\n", 0, 0);
    exp_q.push_back(mk(0, 0, 0, 0, 3, 0));
    run("DEL\n", 0, 0);
    exp_q.push_back(mk(0, 0, 0, 0, 4, 0));
    exp_q.push_back(mk(1, 0, 0, 0, 6, 0));
    run(":TYPE;:BAR;*CLS\n", 0, 1);
    msg = "";
    repeat (8) begin
      msg = {msg, ":TYPE;"};
      exp_q.push_back(mk(0, 0, 0, 0, 4, 0));
    end
    hold_off = 1'b1;
    fork
      begin
        repeat (60) @(posedge ref_clk);
        hold_off = 1'b0;
      end
    join_none
    run({msg, ":TYPE\n"}, 0, 1);
    for (int i = 0; i < 24; i++) begin
      rb = (i < 4) ? edge_tab[i] : 8'($urandom_range(255));
      resp_q.push_back((rb >= 8'h61 && rb <= 8'h7A) ? rb - 8'h20 : rb);
      resp_byte_in <= rb;
      resp_valid_in <= 1'b1;
      do @(posedge ref_clk); while (clk_en !== 1'b1);
    end
    resp_valid_in <= 1'b0;
    resp_byte_in <= ~rb;
    repeat (6) @(posedge ref_clk);
    check(16'(resp_q.size()), 16'h0000);
    give_verdict();
  end
endmodule : command_message_parser_tb_top
